// *** include/flpe_defs.vh ***
// constants for the fault-log and protection-enable register slice
// assumes a plain register port with one-cycle read latency at 100 MHz
`ifndef FLPE_DEFS_VH
`define FLPE_DEFS_VH

// ****************************************
// register map (byte addresses)
// ****************************************
`define FLPE_ADDR_W 12
`define FLPE_OFS_LOG_LO 12'h058
`define FLPE_OFS_LOG_HI 12'h05c
`define FLPE_OFS_PROT 12'h064

// ****************************************
// fields
// ****************************************
`define FLPE_SIZE_LSB 9
`define FLPE_SIZE_MSB 11
`define FLPE_BASE_LSB 12
`define FLPE_BASE_LO_W 20
`define FLPE_EN_BIT 31
`define FLPE_STS_BIT 0
`define FLPE_ZERO32 32'h0000_0000
`define FLPE_ZERO3 3'h0

// ****************************************
// timing
// ****************************************
`define FLPE_SETTLE_NS 20
`define FLPE_CLK_NS 10

`endif

// *** logic/flpe_sync2.v ***
// two-flop synchroniser for a level from another domain
// assumes the level is stable for several clk periods
`timescale 1ns/1ns
module flpe_sync2 (
	clk,
	rst_n,
	d,
	q
);
	input wire clk;
	input wire rst_n;
	input wire d;
	output reg q;
	reg meta_r;
	always @(posedge clk) begin
		if (!rst_n) begin
			meta_r <= 1'b0;
			q <= 1'b0;
		end else begin
			meta_r <= d;
			q <= meta_r;
		end
	end
endmodule // flpe_sync2

// *** logic/flpe_hold_reg.v ***
// one staged/active register pair: software stage and adopted copy
// assumes load is a one-cycle pulse from the same clock
`timescale 1ns/1ns
module flpe_hold_reg #(
	parameter W = 8
) (
	clk,
	rst_n,
	wr_en,
	wr_data,
	load,
	staged,
	active
);
	input wire clk;
	input wire rst_n;
	input wire wr_en;
	input wire [W-1:0] wr_data;
	input wire load;
	output reg [W-1:0] staged;
	output reg [W-1:0] active;
	always @(posedge clk) begin
		if (!rst_n) begin
			staged <= {W{1'b0}};
			active <= {W{1'b0}};
		end else begin
			if (wr_en) begin
				staged <= wr_data;
			end
			if (load) begin
				active <= staged;
			end
		end
	end
endmodule // flpe_hold_reg

// *** logic/flpe_regs.v ***
// fault-log base register and protected-region enable register
// assumes one clk, synchronous active-low reset, plain register port;
// capabilities are straps from the capability register, held stable
//
// Our own choice: the plain strobed port.
`timescale 1ns/1ns
`include "flpe_defs.vh"
module flpe_regs #(
	parameter HOST_ADDR_WIDTH = 48,
	parameter SETTLE_NS = `FLPE_SETTLE_NS
) (
	clk,
	rst_n,
	reg_addr,
	reg_wdata,
	reg_wr,
	reg_rd,
	reg_rdata,
	advanced_logging_capability,
	low_region_capability,
	high_region_capability,
	set_log_pointer_cmd,
	drain_done,
	log_base_active,
	log_size_active,
	log_pointer_set,
	protect_active,
	protect_block,
	remap_fault_block
);
	input wire clk;
	input wire rst_n;
	input wire [`FLPE_ADDR_W-1:0] reg_addr;
	input wire [31:0] reg_wdata;
	input wire reg_wr;
	input wire reg_rd;
	output reg [31:0] reg_rdata;
	input wire advanced_logging_capability;
	input wire low_region_capability;
	input wire high_region_capability;
	input wire set_log_pointer_cmd;
	input wire drain_done;
	output reg [63:0] log_base_active;
	output reg [2:0] log_size_active;
	output reg log_pointer_set;
	output reg protect_active;
	output reg protect_block;
	output reg remap_fault_block;

	localparam BW = HOST_ADDR_WIDTH - `FLPE_BASE_LSB;
	localparam [7:0] SETTLE_CYC = (SETTLE_NS + `FLPE_CLK_NS - 1) / `FLPE_CLK_NS;
	localparam ST_IDLE = 3'b001;
	localparam ST_DRAIN = 3'b010;
	localparam ST_SETTLE = 3'b100;

	// ****************************************
	// decode
	// ****************************************
	wire log_cap = advanced_logging_capability;
	wire prot_cap = low_region_capability | high_region_capability;
	wire wr_lo = reg_wr & (reg_addr == `FLPE_OFS_LOG_LO) & log_cap;
	wire wr_hi = reg_wr & (reg_addr == `FLPE_OFS_LOG_HI) & log_cap;
	wire wr_prot = reg_wr & (reg_addr == `FLPE_OFS_PROT) & prot_cap;
	wire drain_s;

	flpe_sync2 u_drain_sync (
		.clk(clk),
		.rst_n(rst_n),
		.d(drain_done),
		.q(drain_s)
	);

	// ****************************************
	// fault-log register
	// ****************************************
	// base split across two dwords; only HOST_ADDR_WIDTH-12 bits stored
	wire [BW-1:0] base_wdata;
	wire [BW-1:0] base_stage;
	wire [BW-1:0] base_act;
	wire [BW-1:0] base_cur;
	wire [2:0] size_stage;
	wire [2:0] size_act;
	wire [63:0] base_wide;
	wire [63:0] base_stage_wide;
	wire cmd_load = set_log_pointer_cmd & log_cap;

	assign base_wide = {{(64-BW){1'b0}}, base_stage};
	assign base_stage_wide = base_wide << `FLPE_BASE_LSB;
	assign base_cur = base_stage;
	assign base_wdata = wr_lo
		? {base_cur[BW-1:`FLPE_BASE_LO_W], reg_wdata[31:`FLPE_BASE_LSB]}
		: {reg_wdata[BW-`FLPE_BASE_LO_W-1:0], base_cur[`FLPE_BASE_LO_W-1:0]};

	flpe_hold_reg #(
		.W(BW)
	) u_base (
		.clk(clk),
		.rst_n(rst_n),
		.wr_en(wr_lo | wr_hi),
		.wr_data(base_wdata),
		.load(cmd_load),
		.staged(base_stage),
		.active(base_act)
	);

	flpe_hold_reg #(
		.W(3)
	) u_size (
		.clk(clk),
		.rst_n(rst_n),
		.wr_en(wr_lo),
		.wr_data(reg_wdata[`FLPE_SIZE_MSB:`FLPE_SIZE_LSB]),
		.load(cmd_load),
		.staged(size_stage),
		.active(size_act)
	);

	always @(posedge clk) begin
		if (!rst_n) begin
			log_base_active <= 64'h0;
			log_size_active <= `FLPE_ZERO3;
			log_pointer_set <= 1'b0;
		end else begin
			log_base_active <= {{(64-BW){1'b0}}, base_act} << `FLPE_BASE_LSB;
			log_size_active <= size_act;
			log_pointer_set <= cmd_load;
		end
	end

	// ****************************************
	// protection enable and status
	// ****************************************
	// status follows enable after a settle gap; only a rise of enable also waits for drain to complete
	reg [2:0] state_r;
	reg [2:0] state_nxt;
	reg en_r;
	reg sts_r;
	reg sts_nxt;
	reg [7:0] cnt_r;
	reg [7:0] cnt_nxt;

	always @* begin
		state_nxt = state_r;
		sts_nxt = sts_r;
		cnt_nxt = cnt_r;
		case (state_r)
			ST_IDLE: begin
				if (en_r != sts_r) begin
					state_nxt = en_r ? ST_DRAIN : ST_SETTLE;
					cnt_nxt = SETTLE_CYC;
				end
			end
			ST_DRAIN: begin
				if (drain_s) begin
					state_nxt = ST_SETTLE;
				end
			end
			ST_SETTLE: begin
				if (cnt_r <= 8'h01) begin
					sts_nxt = en_r;
					state_nxt = ST_IDLE;
				end else begin
					cnt_nxt = cnt_r - 8'h01;
				end
			end
			default: begin
				state_nxt = ST_IDLE;
			end
		endcase
	end

	always @(posedge clk) begin
		if (!rst_n) begin
			state_r <= ST_IDLE;
			en_r <= 1'b0;
			sts_r <= 1'b0;
			cnt_r <= 8'h00;
			protect_active <= 1'b0;
			protect_block <= 1'b0;
			remap_fault_block <= 1'b0;
		end else begin
			state_r <= state_nxt;
			sts_r <= sts_nxt;
			cnt_r <= cnt_nxt;
			if (wr_prot) begin
				en_r <= reg_wdata[`FLPE_EN_BIT];
			end
			protect_active <= sts_nxt;
			protect_block <= en_r | sts_nxt;
			remap_fault_block <= en_r | sts_nxt;
		end
	end

	// ****************************************
	// read port
	// ****************************************
	always @(posedge clk) begin
		if (!rst_n) begin
			reg_rdata <= `FLPE_ZERO32;
		end else if (reg_rd) begin
			reg_rdata <= `FLPE_ZERO32;
			if (log_cap && reg_addr == `FLPE_OFS_LOG_LO) begin
				reg_rdata <= base_stage_wide[31:0];
				reg_rdata[`FLPE_SIZE_MSB:`FLPE_SIZE_LSB] <= size_stage;
			end else if (log_cap && reg_addr == `FLPE_OFS_LOG_HI) begin
				reg_rdata <= base_stage_wide[63:32];
			end else if (reg_addr == `FLPE_OFS_PROT) begin
				reg_rdata[`FLPE_EN_BIT] <= en_r;
				reg_rdata[`FLPE_STS_BIT] <= sts_r;
			end
		end else begin
			reg_rdata <= `FLPE_ZERO32;
		end
	end
endmodule // flpe_regs

// *** test/flpe_monitor.sv ***
// assertions on the ports of the fault-log and protect-enable registers
// assumes capability straps change only while reset is held
`timescale 1ns/1ns
`include "flpe_defs.vh"
module flpe_monitor #(
	parameter HOST_ADDR_WIDTH = 48
) (
	input wire clk,
	input wire rst_n,
	input wire [`FLPE_ADDR_W-1:0] reg_addr,
	input wire reg_wr,
	input wire reg_rd,
	input wire [31:0] reg_rdata,
	input wire advanced_logging_capability,
	input wire low_region_capability,
	input wire high_region_capability,
	input wire set_log_pointer_cmd,
	input wire drain_done,
	input wire [63:0] log_base_active,
	input wire [2:0] log_size_active,
	input wire log_pointer_set,
	input wire protect_active,
	input wire protect_block,
	input wire remap_fault_block
);
	// ****
	// checks
	// ****
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence s_cmd;
		set_log_pointer_cmd && advanced_logging_capability;
	endsequence
	sequence s_rd_prot;
		reg_rd && reg_addr == `FLPE_OFS_PROT;
	endsequence
	a_rd_idle: assert property (!$past(reg_rd) |-> reg_rdata == 0)
		else $error("read data outside the answer cycle");
	a_log_nocap: assert property (reg_rd && !advanced_logging_capability &&
		reg_addr[11:3] == 9'h00b |=> reg_rdata == 0)
		else $error("fault-log word not zero without capability");
	a_prot_resv: assert property (s_rd_prot |=> reg_rdata[30:1] == 0)
		else $error("enable register reserved bits set");
	a_ptr_pulse: assert property (s_cmd |=> log_pointer_set ##1 !log_pointer_set)
		else $error("set pulse missing or too long");
	a_adopt_only: assert property (!$past(set_log_pointer_cmd) && !$past(set_log_pointer_cmd, 2)
		|-> $stable(log_base_active) && $stable(log_size_active))
		else $error("adopted log values moved without command");
	a_base_align: assert property (log_base_active[11:0] == 0 &&
		(log_base_active >> HOST_ADDR_WIDTH) == 0)
		else $error("adopted base not aligned or too wide");
	a_block_cause: assert property ($rose(protect_block) |->
		$past(reg_wr) || $past(reg_wr, 2))
		else $error("blocking rose without a write");
	a_fault_supp: assert property (remap_fault_block == protect_block)
		else $error("fault suppression differs from blocking");
	a_active_drain: assert property ($rose(protect_active) |->
		protect_block && $past(drain_done, 3))
		else $error("status set before drain or without enable");
	a_prot_ro: assert property (!low_region_capability && !high_region_capability
		|-> !protect_block)
		else $error("enable took effect without region capability");
endmodule // flpe_monitor
bind flpe_regs flpe_monitor #(.HOST_ADDR_WIDTH(HOST_ADDR_WIDTH)) mon_u (.clk, .rst_n, .reg_addr, .reg_wr, .reg_rd,
	.reg_rdata, .advanced_logging_capability, .low_region_capability, .high_region_capability,
	.set_log_pointer_cmd, .drain_done, .log_base_active, .log_size_active, .log_pointer_set,
	.protect_active, .protect_block, .remap_fault_block);

// *** test/tb_top.sv ***
// self-checking bench for the fault-log and protect-enable registers
// assumes flpe_regs with bound monitor, one 100 MHz clock
`timescale 1ns/1ns
`include "flpe_defs.vh"
module tb_top;
	reg clk = 0, rst_n = 0, wr = 0, rd = 0, cmd = 0, drain = 0, alc = 1, lrc = 1, hrc = 0;
	reg [11:0] addr = 0;
	reg [31:0] wd = 0;
	wire [31:0] rdata;
	wire [63:0] lba;
	wire [2:0] lsa;
	wire lps, pa, pb, rfb;
	integer failures = 0, compares = 0, i;
	always #5 clk = ~clk;
	flpe_regs #(.HOST_ADDR_WIDTH(48)) dut_u (.clk(clk), .rst_n(rst_n), .reg_addr(addr), .reg_wdata(wd),
		.reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata), .advanced_logging_capability(alc),
		.low_region_capability(lrc), .high_region_capability(hrc), .set_log_pointer_cmd(cmd),
		.drain_done(drain), .log_base_active(lba), .log_size_active(lsa),
		.log_pointer_set(lps), .protect_active(pa), .protect_block(pb),
		.remap_fault_block(rfb));
	// ****
	// helpers
	// ****
	task chk(input string n, input [63:0] s, input [63:0] e); begin
		compares = compares + 1;
		if (s !== e) begin
			failures = failures + 1;
			$display("BAD %s exp %h seen %h", n, e, s);
		end
	end
	endtask
	task summarize; begin
		$display("failures %0d compares %0d", failures, compares);
		if (failures == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	end
	endtask
	// straps move only inside reset
	task do_reset(input a, input l, input h); begin
		rst_n <= 0;
		alc <= a;
		lrc <= l;
		hrc <= h;
		repeat (3) @(posedge clk);
		rst_n <= 1;
		@(posedge clk);
	end
	endtask
	task wr_reg(input [11:0] a, input [31:0] d); begin
		addr <= a;
		wd <= d;
		wr <= 1;
		@(posedge clk);
		wr <= 0;
		#1;
	end
	endtask
	task rd_reg(input [11:0] a, input [31:0] e); begin
		addr <= a;
		rd <= 1;
		@(posedge clk);
		rd <= 0;
		#1 chk("rdata", rdata, e);
	end
	endtask
	task pulse_cmd(input e); begin
		cmd <= 1;
		@(posedge clk);
		cmd <= 0;
		#1 chk("ptr_set", lps, e);
		repeat (2) @(posedge clk);
		#1;
	end
	endtask
	task wait_pa(input v); begin
		for (i = 0; i < 40 && pa !== v; i = i + 1)
			@(posedge clk);
		#1 chk("active", pa, v);
	end
	endtask
	// ****
	// scenarios
	// ****
	task t_defaults; begin
		for (i = 0; i < 4; i = i + 1)
			rd_reg(12'h058 + 4 * i, 32'h0);
	end
	endtask
	task t_log; begin
		wr_reg(12'h058, 32'hffff_ffff);
		wr_reg(12'h05c, 32'hffff_ffff);
		rd_reg(12'h058, 32'hffff_fe00);
		rd_reg(12'h05c, 32'h0000_ffff);
		chk("base", lba, 64'h0);
		pulse_cmd(1'b1);
		chk("base", lba, 64'h0000_ffff_ffff_f000);
		chk("size", lsa, 3'h7);
		wr_reg(12'h058, 32'h0000_1200);
		rd_reg(12'h058, 32'h0000_1200);
		chk("size", lsa, 3'h7);
		pulse_cmd(1'b1);
		chk("base", lba, 64'h0000_ffff_0000_1000);
		chk("size", lsa, 3'h1);
	end
	endtask
	task t_prot; begin
		drain <= 0;
		// regions left unprogrammed, so none overlaps a reserved one
		wr_reg(12'h064, 32'hffff_fffe);
		repeat (8) @(posedge clk);
		rd_reg(12'h064, 32'h8000_0000);
		chk("block", pb, 1'b1);
		chk("nofault", rfb, 1'b1);
		drain <= 1;
		wait_pa(1);
		rd_reg(12'h064, 32'h8000_0001);
		wr_reg(12'h064, 32'h0);
		wait_pa(0);
		rd_reg(12'h064, 32'h0);
		chk("block", pb, 1'b0);
	end
	endtask
	task t_nocap; begin
		do_reset(0, 0, 0);
		wr_reg(12'h058, 32'hffff_ffff);
		wr_reg(12'h05c, 32'hffff_ffff);
		wr_reg(12'h064, 32'h8000_0000);
		pulse_cmd(1'b0);
		for (i = 0; i < 4; i = i + 1)
			rd_reg(12'h058 + 4 * i, 32'h0);
		chk("block", pb, 1'b0);
	end
	endtask
	initial begin
		do_reset(1, 1, 0);
		t_defaults;
		t_log;
		t_prot;
		t_nocap;
		summarize;
	end
	// whole run is well under a hundred cycles
	initial begin
		#20000;
		failures = failures + 1;
		summarize;
	end
endmodule // tb_top
